// *** rtl/lmu_defs.svh ***
// constants for the load/move instruction unit
`ifndef LMU_DEFS_SVH
`define LMU_DEFS_SVH
`define LMU_OP_OUT_FROM_RAM  8'h15
`define LMU_OP_RAM_CONST     8'h10
`define LMU_OP_RAM_PROG      8'h11
`define LMU_OP_RAM_PROG_IND  8'h12
`define LMU_OP_RAM_IN        8'h13
`define LMU_OP_RAM_RAM       8'h17
`define LMU_CYC_14           5'h0E
`define LMU_CYC_16           5'h10
`define LMU_CYC_18           5'h12
`define LMU_PC_STEP          12'h003
`define LMU_PC_RESET         12'h000
`define LMU_ZERO8            8'h00
`define LMU_ONE5             5'h01
`define LMU_TWO5             5'h02
`define LMU_ZERO5            5'h00
`define LMU_ZERO3            3'h0
`define LMU_PC_DST           12'h001
`define LMU_PC_SRC           12'h002
`endif

// *** rtl/lmu_pkg.sv ***
// types for the load/move instruction unit
`default_nettype none
package lmu_pkg;
    typedef enum logic [3:0] {
        LMU_FETCH_OP, LMU_FETCH_DST, LMU_FETCH_SRC, LMU_PTR_SRC, LMU_PTR_DST,
        LMU_READ, LMU_WRITE, LMU_WAIT, LMU_BAD
    } lmu_state_t;
endpackage
`default_nettype wire

// *** rtl/lmu_core.sv ***
// load/move instruction unit: fetch, decode and execute of the move group
// Notes on behaviour
// - copy RAM byte to output peripheral, 14 cycles
// - write immediate byte into RAM, 14 cycles
// - program memory in page to RAM, 16 cycles
// - both operands via RAM pointers, 18 cycles
// - copy RAM byte to RAM, 16 cycles
// - zero, carry, sign flags never change
// - opcode, destination, source bytes in order
// - program address is page*256 plus offset
`include "lmu_defs.svh"
`default_nettype none
module lmu_core
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rstn,
    // program memory, combinational read
    output logic      [11:0] pm_addr,
    input  wire logic [7:0]  pm_rdata,
    // page selected by page_select_instr
    input  wire logic [3:0]  page_sel,
    // data RAM, combinational read
    output logic      [7:0]  ram_addr,
    input  wire logic [7:0]  ram_rdata,
    output logic      [7:0]  ram_wdata,
    output logic             ram_we,
    // peripherals
    output logic      [7:0]  per_addr,
    input  wire logic [7:0]  in_per_rdata,
    output logic      [7:0]  out_per_wdata,
    output logic             out_per_we,
    // flags in/out and status
    input  wire logic [2:0]  flags_in,
    output logic      [2:0]  flags_out,
    output logic      [11:0] pc,
    output logic             instr_done,
    output logic             illegal_op
);
    import lmu_pkg::*;

    lmu_state_t  st_q, st_d;
    logic [11:0] pc_q, pc_d, pma_q, pma_d;
    logic [7:0]  op_q, op_d, dst_q, dst_d, src_q, src_d, dat_q, dat_d;
    logic [7:0]  ra_q, ra_d, wd_q, wd_d, pa_q, pa_d, ow_q, ow_d;
    logic [4:0]  cnt_q, cnt_d;
    logic        rwe_q, rwe_d, owe_q, owe_d, done_q, done_d, bad_q, bad_d;
    logic [2:0]  fl_q, fl_d;

    function automatic logic [4:0] cyc_of(input logic [7:0] op);
        if (op == `LMU_OP_RAM_PROG || op == `LMU_OP_RAM_RAM)
            cyc_of = `LMU_CYC_16;
        else if (op == `LMU_OP_RAM_PROG_IND)
            cyc_of = `LMU_CYC_18;
        else
            cyc_of = `LMU_CYC_14;
    endfunction

    function automatic logic known(input logic [7:0] op);
        known = op == `LMU_OP_OUT_FROM_RAM || op == `LMU_OP_RAM_CONST ||
                op == `LMU_OP_RAM_PROG || op == `LMU_OP_RAM_PROG_IND ||
                op == `LMU_OP_RAM_IN || op == `LMU_OP_RAM_RAM;
    endfunction

    function automatic logic [11:0] page_addr(input logic [3:0] pg, input logic [7:0] off);
        page_addr = {pg, off};
    endfunction

    always_comb
    begin
        st_d = st_q;
        pc_d = pc_q;
        pma_d = pma_q;
        op_d = op_q;
        dst_d = dst_q;
        src_d = src_q;
        dat_d = dat_q;
        ra_d = ra_q;
        wd_d = wd_q;
        pa_d = pa_q;
        ow_d = ow_q;
        cnt_d = cnt_q + `LMU_ONE5;
        rwe_d = 1'b0;
        owe_d = 1'b0;
        done_d = 1'b0;
        bad_d = bad_q;
        fl_d = flags_in;
        case (st_q)
            LMU_FETCH_OP:
            begin
                cnt_d = `LMU_ONE5;
                op_d = pm_rdata;
                pma_d = pc_q + `LMU_PC_DST;
                st_d = known(pm_rdata) ? LMU_FETCH_DST : LMU_BAD;
            end
            LMU_FETCH_DST:
            begin
                dst_d = pm_rdata;
                pma_d = pc_q + `LMU_PC_SRC;
                st_d = LMU_FETCH_SRC;
            end
            LMU_FETCH_SRC:
            begin
                src_d = pm_rdata;
                ra_d = pm_rdata;
                pa_d = pm_rdata;
                st_d = LMU_READ;
                if (op_q == `LMU_OP_RAM_PROG_IND)
                    st_d = LMU_PTR_SRC;
            end
            LMU_PTR_SRC:
            begin
                src_d = ram_rdata;
                ra_d = dst_q;
                st_d = LMU_PTR_DST;
            end
            LMU_PTR_DST:
            begin
                dst_d = ram_rdata;
                st_d = LMU_READ;
            end
            LMU_READ:
            begin
                pma_d = page_addr(page_sel, src_q);
                if (op_q == `LMU_OP_RAM_CONST)
                    dat_d = src_q;
                else if (op_q == `LMU_OP_RAM_IN)
                    dat_d = in_per_rdata;
                else
                    dat_d = ram_rdata;
                st_d = LMU_WRITE;
            end
            LMU_WRITE:
            begin
                if (op_q == `LMU_OP_RAM_PROG || op_q == `LMU_OP_RAM_PROG_IND)
                    dat_d = pm_rdata;
                st_d = LMU_WAIT;
            end
            LMU_WAIT:
            begin
                // done lands on the last cycle so the next opcode edge is N after this one
                if (cnt_q == cyc_of(op_q) - `LMU_TWO5)
                begin
                    if (op_q == `LMU_OP_OUT_FROM_RAM)
                    begin
                        owe_d = 1'b1;
                        pa_d = dst_q;
                        ow_d = dat_q;
                    end
                    else
                    begin
                        rwe_d = 1'b1;
                        ra_d = dst_q;
                        wd_d = dat_q;
                    end
                end
                else if (cnt_q == cyc_of(op_q) - `LMU_ONE5)
                begin
                    done_d = 1'b1;
                    pc_d = pc_q + `LMU_PC_STEP;
                    pma_d = pc_q + `LMU_PC_STEP;
                    st_d = LMU_FETCH_OP;
                end
            end
            default:
            begin
                bad_d = 1'b1; // unknown opcodes are outside this unit; park here
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            st_q <= LMU_FETCH_OP;
            pc_q <= `LMU_PC_RESET;
            pma_q <= `LMU_PC_RESET;
            op_q <= `LMU_ZERO8;
            dst_q <= `LMU_ZERO8;
            src_q <= `LMU_ZERO8;
            dat_q <= `LMU_ZERO8;
            ra_q <= `LMU_ZERO8;
            wd_q <= `LMU_ZERO8;
            pa_q <= `LMU_ZERO8;
            ow_q <= `LMU_ZERO8;
            cnt_q <= `LMU_ZERO5;
            rwe_q <= 1'b0;
            owe_q <= 1'b0;
            done_q <= 1'b0;
            bad_q <= 1'b0;
            fl_q <= `LMU_ZERO3;
        end
        else
        begin
            st_q <= st_d;
            pc_q <= pc_d;
            pma_q <= pma_d;
            op_q <= op_d;
            dst_q <= dst_d;
            src_q <= src_d;
            dat_q <= dat_d;
            ra_q <= ra_d;
            wd_q <= wd_d;
            pa_q <= pa_d;
            ow_q <= ow_d;
            cnt_q <= cnt_d;
            rwe_q <= rwe_d;
            owe_q <= owe_d;
            done_q <= done_d;
            bad_q <= bad_d;
            fl_q <= fl_d;
        end
    end

    assign pm_addr = pma_q;
    assign ram_addr = ra_q;
    assign ram_wdata = wd_q;
    assign ram_we = rwe_q;
    assign per_addr = pa_q;
    assign out_per_wdata = ow_q;
    assign out_per_we = owe_q;
    assign flags_out = fl_q;
    assign pc = pc_q;
    assign instr_done = done_q;
    assign illegal_op = bad_q;
endmodule
`default_nettype wire

// *** bench/lmu_mem.sv ***
// memories and peripheral registers beside the unit
`default_nettype none
module lmu_mem
(
    input  wire logic        clk,
    // program memory and data ram
    input  wire logic [11:0] pm_addr,
    output logic      [7:0]  pm_rdata,
    input  wire logic [7:0]  ram_addr,
    output logic      [7:0]  ram_rdata,
    input  wire logic [7:0]  ram_wdata,
    input  wire logic        ram_we,
    // peripherals
    input  wire logic [7:0]  per_addr,
    output logic      [7:0]  in_per_rdata,
    input  wire logic [7:0]  out_per_wdata,
    input  wire logic        out_per_we
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] pm [4096];
    logic [7:0] ram [256];
    logic [7:0] inp [256];
    logic [7:0] outp [256];
    assign pm_rdata = pm[pm_addr];
    assign ram_rdata = ram[ram_addr];
    assign in_per_rdata = inp[per_addr];
    always @(posedge clk)
    begin
        if (ram_we) ram[ram_addr] <= ram_wdata;
        if (out_per_we) outp[per_addr] <= out_per_wdata;
    end
endmodule
`default_nettype wire

// *** bench/lmu_core_asserts.sv ***
// checker for the move unit
`default_nettype none
module lmu_core_asserts
(
    // clock and reset
    input wire logic        clk,
    input wire logic        rstn,
    // watched
    input wire logic [2:0]  flags_in,
    input wire logic [2:0]  flags_out,
    input wire logic [11:0] pc,
    input wire logic        instr_done,
    input wire logic        illegal_op,
    input wire logic        ram_we,
    input wire logic        out_per_we
);
    timeunit 1ns;
    timeprecision 1ps;
    // cycles since opcode edge; wraps harmlessly once halted
    logic [4:0] cnt_q;
    logic [4:0] cnt_d;
    always_comb
    begin
        cnt_d = !rstn ? 5'h00 : (instr_done ? 5'h01 : cnt_q + 5'h01);
    end
    always_ff @(posedge clk)
    begin
        cnt_q <= cnt_d;
    end
    default clocking dc @(posedge clk); endclocking
    default disable iff (!rstn);
    a_flags_kept: assert property ($past(rstn) |-> flags_out == $past(flags_in))
        else $error("flags");
    a_done_len: assert property (instr_done |-> cnt_q inside {5'h0E, 5'h10, 5'h12})
        else $error("length");
    a_write_slot: assert property (ram_we || out_per_we |-> cnt_q inside {5'h0D, 5'h0F, 5'h11})
        else $error("write slot");
    a_write_done: assert property (ram_we || out_per_we |=> instr_done)
        else $error("done");
    a_done_gap: assert property (instr_done |=> !instr_done [*8])
        else $error("gap");
    a_pc_step: assert property (instr_done |-> pc == $past(pc) + 12'h003)
        else $error("pc step");
    a_pc_hold: assert property ($past(rstn) && !instr_done |-> $stable(pc))
        else $error("pc moved");
    a_halt_quiet: assert property (illegal_op |=> illegal_op && !ram_we && !out_per_we)
        else $error("halt");
    c_ram: cover property (ram_we);
    c_out: cover property (out_per_we);
    c_halt: cover property (illegal_op);
endmodule
bind lmu_core lmu_core_asserts chk_u
(
    .clk        (clk),
    .rstn       (rstn),
    .flags_in   (flags_in),
    .flags_out  (flags_out),
    .pc         (pc),
    .instr_done (instr_done),
    .illegal_op (illegal_op),
    .ram_we     (ram_we),
    .out_per_we (out_per_we)
);
`default_nettype wire

// *** bench/lmu_core_tb_top.sv ***
// bench for the move unit
`default_nettype none
module lmu_core_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rstn = 1'b0, ram_we, out_per_we, instr_done, illegal_op;
    logic [3:0] page_sel = 4'h2;
    logic [2:0] flags_in = 3'h5, flags_out;
    logic [11:0] pm_addr, pc;
    logic [7:0] pm_rdata, ram_addr, ram_rdata, ram_wdata, per_addr, in_per_rdata, out_per_wdata;
    int num_errors = 0, total_checks = 0, ticks = 0;
    always #10 clk = ~clk;
    lmu_core dut_u
    (
        .clk           (clk),
        .rstn          (rstn),
        .pm_addr       (pm_addr),
        .pm_rdata      (pm_rdata),
        .page_sel      (page_sel),
        .ram_addr      (ram_addr),
        .ram_rdata     (ram_rdata),
        .ram_wdata     (ram_wdata),
        .ram_we        (ram_we),
        .per_addr      (per_addr),
        .in_per_rdata  (in_per_rdata),
        .out_per_wdata (out_per_wdata),
        .out_per_we    (out_per_we),
        .flags_in      (flags_in),
        .flags_out     (flags_out),
        .pc            (pc),
        .instr_done    (instr_done),
        .illegal_op    (illegal_op)
    );
    lmu_mem mem_u
    (
        .clk           (clk),
        .pm_addr       (pm_addr),
        .pm_rdata      (pm_rdata),
        .ram_addr      (ram_addr),
        .ram_rdata     (ram_rdata),
        .ram_wdata     (ram_wdata),
        .ram_we        (ram_we),
        .per_addr      (per_addr),
        .in_per_rdata  (in_per_rdata),
        .out_per_wdata (out_per_wdata),
        .out_per_we    (out_per_we)
    );
    task automatic check(input logic [11:0] got, exp);
        total_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED %0t got %0h want %0h", $time, got, exp);
        end
    endtask
    // one instruction: length, pc, flags, stored byte (o picks output register)
    task automatic step(input logic [11:0] n, pcx, input logic o, input logic [7:0] a, v);
        logic [11:0] k;
        k = 12'h000;
        do
        begin
            @(negedge clk);
            k++;
        end
        while (instr_done !== 1'b1 && k < 12'h028);
        check(k, n);
        check(pc, pcx);
        check(12'(flags_out), 12'(flags_in));
        check(12'(o ? mem_u.outp[a] : mem_u.ram[a]), 12'(v));
        $display("test to pc %0h ended", pcx);
    endtask
    task automatic t_const;
        step(12'h00E, 12'h003, 1'b0, 8'h18, 8'h82);
    endtask
    task automatic t_ram;
        step(12'h010, 12'h006, 1'b0, 8'h28, 8'h82);
    endtask
    task automatic t_out;
        step(12'h00E, 12'h009, 1'b1, 8'h02, 8'h82);
    endtask
    task automatic t_in;
        step(12'h00E, 12'h00C, 1'b0, 8'h32, 8'h64);
    endtask
    task automatic t_page;
        step(12'h010, 12'h00F, 1'b0, 8'h3C, 8'h5A);
    endtask
    task automatic t_ind;
        page_sel = 4'h3;
        flags_in = 3'h2;
        step(12'h012, 12'h012, 1'b0, 8'h5A, 8'hA5);
    endtask
    // no fixed figure exists for a halt, so a quiet stretch is watched
    task automatic t_bad;
        repeat (20) @(negedge clk);
        check(12'(illegal_op), 12'h001);
        check(pc, 12'h012);
        $display("halt test ended");
    endtask
    // reset in mid-run must clear the halt and restart from address zero
    task automatic t_reset;
        rstn = 1'b0;
        repeat (2) @(negedge clk);
        check(12'(illegal_op), 12'h000);
        check(pc, 12'h000);
        rstn = 1'b1;
        step(12'h00E, 12'h003, 1'b0, 8'h18, 8'h82);
    endtask
    task automatic end_of_test;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    localparam logic [7:0] PROG [21] = '{8'h10, 8'h18, 8'h82, 8'h17, 8'h28, 8'h18, 8'h15,
        8'h02, 8'h28, 8'h13, 8'h32, 8'h0A, 8'h11, 8'h3C, 8'h0A, 8'h12, 8'h46, 8'h50, 8'hFF,
        8'h00, 8'h00};
    always @(posedge clk)
    begin
        ticks++;
        if (ticks == 500)
        begin
            num_errors++;
            end_of_test;
        end
    end
    initial
    begin
        foreach (PROG[i]) mem_u.pm[i] = PROG[i];
        mem_u.pm[12'h20A] = 8'h5A;
        mem_u.pm[12'h30B] = 8'hA5;
        mem_u.inp[8'h0A] = 8'h64;
        mem_u.ram[8'h50] = 8'h0B;
        mem_u.ram[8'h46] = 8'h5A;
        repeat (5) @(negedge clk);
        rstn = 1'b1;
        t_const;
        t_ram;
        t_out;
        t_in;
        t_page;
        t_ind;
        t_bad;
        t_reset;
        end_of_test;
    end
endmodule
`default_nettype wire
